/* include/cmpone_regs.svh */
// register offsets, field positions and constants of the comparator one control block
`ifndef CMPONE_REGS_SVH
`define CMPONE_REGS_SVH

`define CMPONE_CTL_OFFSET        12'h004
`define CMPONE_STATUS_OFFSET     12'h008
`define CMPONE_DELAY_OFFSET      12'h010
`define CMPONE_ADDR_BITS         12

`define CMPONE_CTL_RESET         32'h0000_0000
`define CMPONE_CTL_WMASK         32'hF3B8_3F7F
`define CMPONE_ZERO_WORD         32'h0000_0000

`define CMPONE_PRESET_BIT        31
`define CMPONE_PSEL_HI           30
`define CMPONE_PSEL_LO           28
`define CMPONE_NSEL_HI           25
`define CMPONE_NSEL_LO           24
`define CMPONE_FILTER_DISABLE_BIT         23
`define CMPONE_NFCLK_HI          21
`define CMPONE_NFCLK_LO          20
`define CMPONE_POL_BIT           19
`define CMPONE_DIE_BIT           13
`define CMPONE_DEN_BIT           12
`define CMPONE_DSRC_HI           11
`define CMPONE_DSRC_LO           10
`define CMPONE_DEDGE_HI          9
`define CMPONE_DEDGE_LO          8
`define CMPONE_BRK_BIT           6
`define CMPONE_FEDGE_HI          5
`define CMPONE_FEDGE_LO          4
`define CMPONE_HYS_HI            3
`define CMPONE_HYS_LO            2
`define CMPONE_IE_BIT            1
`define CMPONE_EN_BIT            0

`define CMPONE_ST_CFLAG_BIT      1
`define CMPONE_ST_COUT_BIT       3
`define CMPONE_ST_DFLAG_BIT      5
`define CMPONE_ST_DOUT_BIT       7

`define CMPONE_DELAY_BITS        9
`define CMPONE_DIV_BITS          4
`define CMPONE_DIV1_LAST         4'h0
`define CMPONE_DIV2_LAST         4'h1
`define CMPONE_DIV4_LAST         4'h3
`define CMPONE_DIV16_LAST        4'hF
`define CMPONE_FILTER_SAMPLES    3
`define CMPONE_PULSE_CHANNELS    3

`endif

/* include/cmpone_pkg.sv */
// types shared by the comparator one control block
package cmpone_pkg;

  typedef enum logic [1:0] {
    CMPONE_EDGE_NONE,
    CMPONE_EDGE_RISE,
    CMPONE_EDGE_FALL,
    CMPONE_EDGE_BOTH
  } cmpone_edge_type;

  typedef enum logic {
    CMPONE_DLY_IDLE,
    CMPONE_DLY_WAIT
  } cmpone_dly_state_type;

endpackage

/* verilog/cmpone_filter.sv */
// noise filter: majority-free run filter on a divided sample tick
`timescale 1ns/1ps
`include "cmpone_regs.svh"

module cmpone_filter
  import cmpone_pkg::*;
#(
  parameter int SAMPLES = `CMPONE_FILTER_SAMPLES
)
(
  input  wire logic i_clock,
  input  wire logic i_srst,
  input  wire logic i_tick,
  input  wire logic i_level,
  output logic      o_level
);

  typedef struct packed {
    logic [SAMPLES-1:0] hist;
    logic               level;
  } cmpone_filt_state_type;

  cmpone_filt_state_type st_r;
  cmpone_filt_state_type st_nxt;

  // ***********************************
  // sampling and acceptance
  // ***********************************
  always_comb
  begin
    st_nxt = st_r;
    if (i_tick)
    begin
      st_nxt.hist = {st_r.hist[SAMPLES-2:0], i_level};
    end
    if (&st_nxt.hist)
    begin
      st_nxt.level = 1'b1;
    end
    else if (~|st_nxt.hist)
    begin
      st_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule

/* verilog/cmpone_control.sv */
// comparator one control: register, input steering, filter, edge flags, delayed sampling, brake route
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cmpone_regs.svh"

// Summary of operation
// - bit 31 gives result preset value
// - bits 30:28 pick positive input
// - bits 25:24 pick negative input
// - bit 23 set bypasses noise filter
// - bits 21:20 divide filter clock 1/2/4/16
// - bit 19 inverts comparator output
// - bit 13 gates delayed sample interrupt
// - bit 12 enables delayed sample mode
// - bits 11:10 choose pulse channel source
// - bits 9:8 choose trigger edge
// - bit 6 routes brake source
// - bits 5:4 choose flag setting edges
// - bits 3:2 select hysteresis setting
// - bit 1 gates comparator interrupt
// - comparator interrupt wakes from power-down
// - output change sets flag, write one clears
// - synced output readable, zero when disabled
// - nine-bit delay count register
// - delayed output change sets flag, interrupt
module cmpone_control
  import cmpone_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_compare_raw,
  input  wire logic [2:0]  i_pulse_channel,
  output logic             o_compare_enable,
  output logic [2:0]       o_positive_input_select,
  output logic [1:0]       o_negative_input_select,
  output logic [1:0]       o_hysteresis_select,
  output logic             o_compare_one_output,
  output logic             o_delayed_one_output,
  output logic             o_brake,
  output logic             o_compare_irq,
  output logic             o_delayed_irq,
  output logic             o_wakeup
);

  // one packed state word keeps reset and next state in one place
  typedef struct packed {
    logic [31:0]                         ctl;
    logic [`CMPONE_DELAY_BITS-1:0]       delay;
    logic                                cflag;
    logic                                dflag;
    logic [2:0]                          sync;
    logic                                level;
    logic [`CMPONE_DIV_BITS-1:0]         div_cnt;
    logic                                result;
    logic                                res_prev;
    logic                                pulse_prev;
    cmpone_dly_state_type                dstate;
    logic [`CMPONE_DELAY_BITS-1:0]       dcnt;
    logic                                dout;
    logic                                wr_pend;
    logic [`CMPONE_ADDR_BITS-1:0]        waddr;
    logic [31:0]                         rdata;
  } cmpone_state_type;

  cmpone_state_type st_r;
  cmpone_state_type st_nxt;

  logic [`CMPONE_DIV_BITS-1:0] div_last;
  logic                        tick;
  logic                        filt_level;
  logic                        acc;
  logic                        pulse_sel;
  logic                        trig;
  logic                        enable;
  logic                        den;
  logic                        cset;
  logic                        dset;
  logic                        cclr;
  logic                        dclr;
  logic [31:0]                 rd_word;
  logic [`CMPONE_ADDR_BITS-1:0] raddr;
  cmpone_edge_type             fedge;
  cmpone_edge_type             dedge;

  // ***********************************
  // noise filter
  // ***********************************
  cmpone_filter #(
    .SAMPLES (`CMPONE_FILTER_SAMPLES)
  ) u_filter (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_tick  (tick),
    .i_level (st_r.level),
    .o_level (filt_level)
  );

  // ***********************************
  // field decode and read mux
  // ***********************************
  always_comb
  begin
    enable = st_r.ctl[`CMPONE_EN_BIT];
    den    = st_r.ctl[`CMPONE_DEN_BIT];
    fedge  = cmpone_edge_type'(st_r.ctl[`CMPONE_FEDGE_HI:`CMPONE_FEDGE_LO]);
    dedge  = cmpone_edge_type'(st_r.ctl[`CMPONE_DEDGE_HI:`CMPONE_DEDGE_LO]);
    unique case (st_r.ctl[`CMPONE_NFCLK_HI:`CMPONE_NFCLK_LO])
      2'b00: div_last = `CMPONE_DIV1_LAST;
      2'b01: div_last = `CMPONE_DIV2_LAST;
      2'b10: div_last = `CMPONE_DIV4_LAST;
      2'b11: div_last = `CMPONE_DIV16_LAST;
    endcase
    // divider idles at zero while disabled, so sampling starts a full period after enable
    tick = enable && (st_r.div_cnt == div_last);
    acc = st_r.ctl[`CMPONE_FILTER_DISABLE_BIT] ? st_r.level : filt_level;
    unique case (st_r.ctl[`CMPONE_DSRC_HI:`CMPONE_DSRC_LO])
      2'b00:   pulse_sel = i_pulse_channel[0];
      2'b01:   pulse_sel = i_pulse_channel[1];
      2'b10:   pulse_sel = i_pulse_channel[2];
      default: pulse_sel = st_r.pulse_prev;
    endcase
    unique case (dedge)
      CMPONE_EDGE_NONE: trig = 1'b0;
      CMPONE_EDGE_RISE: trig = pulse_sel & ~st_r.pulse_prev;
      CMPONE_EDGE_FALL: trig = ~pulse_sel & st_r.pulse_prev;
      CMPONE_EDGE_BOTH: trig = pulse_sel ^ st_r.pulse_prev;
    endcase
    unique case (fedge)
      CMPONE_EDGE_NONE: cset = 1'b0;
      CMPONE_EDGE_RISE: cset = st_r.result & ~st_r.res_prev;
      CMPONE_EDGE_FALL: cset = ~st_r.result & st_r.res_prev;
      CMPONE_EDGE_BOTH: cset = st_r.result ^ st_r.res_prev;
    endcase
    cset = cset && enable;
    raddr = i_haddr[`CMPONE_ADDR_BITS-1:0];
    rd_word = `CMPONE_ZERO_WORD;
    unique case (raddr)
      `CMPONE_CTL_OFFSET:    rd_word = st_r.ctl;
      `CMPONE_STATUS_OFFSET:
      begin
        rd_word[`CMPONE_ST_CFLAG_BIT] = st_r.cflag;
        rd_word[`CMPONE_ST_COUT_BIT]  = st_r.result & enable;
        rd_word[`CMPONE_ST_DFLAG_BIT] = st_r.dflag;
        rd_word[`CMPONE_ST_DOUT_BIT]  = st_r.dout;
      end
      `CMPONE_DELAY_OFFSET:  rd_word[`CMPONE_DELAY_BITS-1:0] = st_r.delay;
      default:               rd_word = `CMPONE_ZERO_WORD;
    endcase
  end

  // ***********************************
  // next state
  // ***********************************
  always_comb
  begin
    st_nxt = st_r;
    cclr   = 1'b0;
    dclr   = 1'b0;
    dset   = 1'b0;
    // raw comparator passes three stages; only stage two feeds stage three
    st_nxt.sync = {st_r.sync[1:0], i_compare_raw};
    if (st_r.sync[1] == st_r.sync[2])
    begin
      st_nxt.level = st_r.sync[2];
    end
    st_nxt.div_cnt = (!enable || tick) ? '0 : st_r.div_cnt + 1'b1;
    if (!enable)
    begin
      st_nxt.result   = st_r.ctl[`CMPONE_PRESET_BIT];
      st_nxt.res_prev = st_r.ctl[`CMPONE_PRESET_BIT];
    end
    else
    begin
      st_nxt.result   = acc ^ st_r.ctl[`CMPONE_POL_BIT];
      st_nxt.res_prev = st_r.result;
    end
    st_nxt.pulse_prev = pulse_sel;
    if (!den)
    begin
      st_nxt.dstate = CMPONE_DLY_IDLE;
      st_nxt.dout   = 1'b0;
    end
    else
    begin
      unique case (st_r.dstate)
        CMPONE_DLY_IDLE:
        begin
          if (trig)
          begin
            st_nxt.dstate = CMPONE_DLY_WAIT;
            st_nxt.dcnt   = st_r.delay;
          end
        end
        CMPONE_DLY_WAIT:
        begin
          if (st_r.dcnt == '0)
          begin
            st_nxt.dstate = CMPONE_DLY_IDLE;
            st_nxt.dout   = st_r.result;
          end
          else
          begin
            st_nxt.dcnt = st_r.dcnt - 1'b1;
          end
        end
      endcase
    end
    // clearing the mode drops dout without a flag; only captures count as changes
    // delayed output change flag
    dset = (st_nxt.dout != st_r.dout) && den;
    // bus data phase of a write; always ready, one wait-free cycle
    if (st_r.wr_pend)
    begin
      unique case (st_r.waddr)
        `CMPONE_CTL_OFFSET:    st_nxt.ctl = i_hwdata & `CMPONE_CTL_WMASK;
        `CMPONE_STATUS_OFFSET:
        begin
          cclr = i_hwdata[`CMPONE_ST_CFLAG_BIT];
          dclr = i_hwdata[`CMPONE_ST_DFLAG_BIT];
        end
        `CMPONE_DELAY_OFFSET:  st_nxt.delay = i_hwdata[`CMPONE_DELAY_BITS-1:0];
        default:               st_nxt.ctl = st_r.ctl;
      endcase
    end
    st_nxt.cflag = cset | (st_r.cflag & ~cclr);
    st_nxt.dflag = dset | (st_r.dflag & ~dclr);
    // capturing the read word here keeps hrdata registered with no wait state
    // address phase: write pends, read word captured now
    st_nxt.wr_pend = 1'b0;
    if (i_hsel && i_hready && i_htrans[1])
    begin
      st_nxt.wr_pend = i_hwrite;
      st_nxt.waddr   = raddr;
      if (!i_hwrite)
      begin
        st_nxt.rdata = rd_word;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_r       <= '0;
      st_r.ctl   <= `CMPONE_CTL_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign o_hreadyout             = 1'b1;
  assign o_hresp                 = 1'b0;
  assign o_hrdata                = st_r.rdata;
  assign o_compare_enable        = st_r.ctl[`CMPONE_EN_BIT];
  assign o_positive_input_select = st_r.ctl[`CMPONE_PSEL_HI:`CMPONE_PSEL_LO];
  assign o_negative_input_select = st_r.ctl[`CMPONE_NSEL_HI:`CMPONE_NSEL_LO];
  assign o_hysteresis_select     = st_r.ctl[`CMPONE_HYS_HI:`CMPONE_HYS_LO];
  assign o_compare_one_output    = st_r.result & st_r.ctl[`CMPONE_EN_BIT];
  assign o_delayed_one_output    = st_r.dout;
  // brake keeps its route while disabled, so with bit 6 clear the preset value reaches the brake input
  // brake route select
  assign o_brake                 = st_r.ctl[`CMPONE_BRK_BIT] ? st_r.dout : st_r.result;
  assign o_compare_irq           = st_r.cflag & st_r.ctl[`CMPONE_IE_BIT];
  assign o_delayed_irq           = st_r.dflag & st_r.ctl[`CMPONE_DIE_BIT];
  // level wake request, no clock needed downstream
  assign o_wakeup                = st_r.cflag & st_r.ctl[`CMPONE_IE_BIT];

endmodule

/* test/cmpone_chk.sv */
// port-level checker of the comparator one control block
`timescale 1ns/1ps
`include "cmpone_regs.svh"
module cmpone_chk
(
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_compare_enable,
  input wire logic [2:0]  o_positive_input_select,
  input wire logic [1:0]  o_negative_input_select,
  input wire logic [1:0]  o_hysteresis_select,
  input wire logic        o_compare_one_output,
  input wire logic        o_delayed_one_output,
  input wire logic        o_brake,
  input wire logic        o_compare_irq,
  input wire logic        o_delayed_irq,
  input wire logic        o_wakeup
);
  // ********************
  // shadow of control
  // ********************
  logic        wr_r;
  logic [31:0] sh_r;
  // the shadow lands on the same edge as the register, so no slack is needed
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wr_r <= 1'b0;
      sh_r <= `CMPONE_ZERO_WORD;
    end
    else
    begin
      wr_r <= i_hsel & i_hready & i_htrans[1] & i_hwrite & (i_haddr[11:0] == `CMPONE_CTL_OFFSET);
      if (wr_r)
        sh_r <= i_hwdata & `CMPONE_CTL_WMASK;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_no_read;
    !(i_hsel && i_hready && i_htrans[1] && !i_hwrite);
  endsequence
  sequence s_dly_off;
    !sh_r[12] ##1 !sh_r[12];
  endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready okay");
  a_read_stands: assert property (s_no_read |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  a_sel_mirror: assert property ({o_positive_input_select, o_negative_input_select, o_hysteresis_select,
    o_compare_enable} == {sh_r[30:28], sh_r[25:24], sh_r[3:2], sh_r[0]})
    else $error("select outputs differ from control");
  a_out_disabled: assert property (!o_compare_enable |-> !o_compare_one_output)
    else $error("output high while disabled");
  a_brake_direct: assert property (o_compare_enable && !sh_r[6] |-> o_brake == o_compare_one_output)
    else $error("brake not direct result");
  a_brake_delayed: assert property (sh_r[6] |-> o_brake == o_delayed_one_output)
    else $error("brake not delayed result");
  a_irq_gate: assert property (o_compare_irq |-> sh_r[1])
    else $error("compare irq while masked");
  a_wake_same: assert property (o_wakeup == o_compare_irq)
    else $error("wakeup differs from compare irq");
  a_dirq_gate: assert property (o_delayed_irq |-> sh_r[13])
    else $error("delayed irq while masked");
  a_dly_cleared: assert property (s_dly_off |-> !o_delayed_one_output)
    else $error("delayed output while mode off");
endmodule
bind cmpone_control cmpone_chk cmpone_chk_i (.*);

/* test/cmpone_partner.sv */
// model of the analog core and the pulse channels
`timescale 1ns/1ps
module cmpone_partner
(
  input  wire logic       i_clock,
  input  wire logic       i_enable,
  input  wire logic       i_level,
  input  wire logic [2:0] i_pulse,
  output logic            o_compare_raw,
  output logic [2:0]      o_pulse_channel
);
  localparam int SETTLE = 40;
  int   cnt_r = 0;
  logic tog_r = 1'b0;
  // settle after enable
  // an unsettled core gives no usable level, so it toggles every cycle
  always_ff @(posedge i_clock)
  begin
    tog_r <= ~tog_r;
    cnt_r <= !i_enable ? 0 : (cnt_r < SETTLE ? cnt_r + 1 : cnt_r);
  end
  assign o_compare_raw   = (cnt_r == SETTLE) ? i_level : tog_r;
  assign o_pulse_channel = i_pulse;
endmodule

/* test/cmpone_control_tb.sv */
// self-checking bench of the comparator one control block
`timescale 1ns/1ps
`include "cmpone_regs.svh"
module cmpone_control_tb;
  logic        i_clock, i_srst, i_hsel, i_hwrite, i_hready, i_compare_raw, level, fl;
  logic        o_hreadyout, o_hresp, o_compare_enable, o_compare_one_output, o_delayed_one_output;
  logic        o_brake, o_compare_irq, o_delayed_irq, o_wakeup;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, xs, v;
  logic [2:0]  i_hsize, i_pulse_channel, pulse, o_positive_input_select;
  logic [1:0]  i_htrans, o_negative_input_select, o_hysteresis_select;
  int          error_cnt, n_checks, cyc, d;

  cmpone_control cmpone_control_i (.*);
  cmpone_partner cmpone_partner_i (.i_clock(i_clock), .i_enable(o_compare_enable), .i_level(level),
    .i_pulse(pulse), .o_compare_raw(i_compare_raw), .o_pulse_channel(i_pulse_channel));
  // the single slave's ready out is the bus ready
  assign i_hready = o_hreadyout;

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] stat(input logic cf, input logic co, input logic df, input logic dq);
    return {24'h00_0000, dq, 1'b0, df, 1'b0, co, 1'b0, cf, 1'b0};
  endfunction
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // master waits on hready, never on a cycle count
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= {20'h0_0000, a};
    i_hwrite <= w;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= dat;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  // ********************
  // main sequence
  // ********************
  initial
  begin
    {i_hsel, i_hwrite, level, fl, pulse, i_htrans, i_haddr, i_hwdata, v, rd} = '0;
    {i_srst, i_hsize, xs, error_cnt, n_checks, cyc, d} = {1'b1, 3'b010, 32'h0000_cf50, 128'h0};
    repeat (12) @(posedge i_clock);
    i_srst <= 1'b0;
    for (int a = 4; a <= 16; a = a * 2)
    begin
      ahb(1'b0, a[11:0], 32'h0000_0000);
      check("reset", rd, 32'h0000_0000);
    end
    ahb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h00C, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h010, 32'h0000_0000);
    check("delay", rd, 32'h0000_01FF);
    for (int i = 0; i < 9; i++)
    begin
      xs = xorshift(xs);
      v = (i == 0) ? 32'hFFFF_FFFF : xs;
      ahb(1'b1, 12'h004, v);
      ahb(1'b0, 12'h004, 32'h0000_0000);
      check("control", rd, v & `CMPONE_CTL_WMASK);
    end
    ahb(1'b1, 12'h004, 32'h0080_0033);
    wt(45);
    ahb(1'b1, 12'h008, 32'h0000_0022);
    @(posedge i_clock) level <= 1'b1;
    wt(10);
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check("status", rd, stat(1'b1, 1'b1, 1'b0, 1'b0));
    check("wakeup", o_wakeup, 1'b1);
    ahb(1'b1, 12'h008, 32'h0000_0002);
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check("clear", rd, stat(1'b0, 1'b1, 1'b0, 1'b0));
    for (int k = 0; k < 8; k++)
    begin
      fl = k[0] ? k[1] : k[2];
      ahb(1'b1, 12'h008, 32'h0000_0002);
      ahb(1'b1, 12'h004, 32'h0080_0001 | (k[2:1] << 4) | (k[0] << 1) | (!k[0] << 19));
      wt(6);
      check("cmp_irq", o_compare_irq, fl & k[0]);
      ahb(1'b0, 12'h008, 32'h0000_0000);
      check("edges", rd, stat(fl, k[0], 1'b0, 1'b0));
    end
    ahb(1'b1, 12'h004, 32'h0080_0000);
    wt(6);
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check("off", rd, stat(1'b1, 1'b0, 1'b0, 1'b0));
    ahb(1'b1, 12'h004, 32'h0030_0001);
    wt(145);
    check("filt_hi", o_compare_one_output, 1'b1);
    @(posedge i_clock) level <= 1'b0;
    wt(24);
    check("filt_hold", o_compare_one_output, 1'b1);
    wt(80);
    check("filt_lo", o_compare_one_output, 1'b0);
    @(posedge i_clock) level <= 1'b1;
    xs = xorshift(xs);
    d = 2 + xs[2:0];
    ahb(1'b1, 12'h004, 32'h0080_3541);
    ahb(1'b1, 12'h010, d);
    wt(10);
    @(posedge i_clock) pulse <= 3'b010;
    repeat (d + 1) @(posedge i_clock);
    #1;
    check("dly_early", o_delayed_one_output, 1'b0);
    wt(2);
    check("dly_out", o_delayed_one_output, 1'b1);
    check("dly_irq", o_delayed_irq, 1'b1);
    check("brake", o_brake, 1'b1);
    @(posedge i_clock) {pulse, level} <= 4'h0;
    wt(d + 8);
    check("dly_fall", o_delayed_one_output, 1'b1);
    ahb(1'b0, 12'h008, 32'h0000_0000);
    check("dly_stat", rd & 32'h0000_00A0, 32'h0000_00A0);
    ahb(1'b1, 12'h004, 32'h0080_0041);
    wt(3);
    check("dly_off", o_delayed_one_output, 1'b0);
    // every source code, falling edge on channel 0, both edges elsewhere; code 11 never triggers
    level <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      pulse <= (j == 0) ? 3'b001 : 3'b000;
      ahb(1'b1, 12'h004, 32'h0080_3041 | (j << 10) | (((j == 0) ? 2 : 3) << 8));
      wt(4);
      @(posedge i_clock) pulse <= (j == 3) ? 3'b111 : pulse ^ (3'b001 << j);
      wt(d + 4);
      check("dly_src", o_delayed_one_output, j != 3);
      ahb(1'b1, 12'h004, 32'h0080_0041);
    end
    finish_test();
  end
endmodule
